/* hdl/rsf_reset_flags.v */
// reset-source flag register, software-triggered resets and reset-effect outputs
// assumes core software on an 8-bit strobe port; rstn is the power-on reset
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "rsf_regs.vh"
// Notes on behaviour
// - flag register bits seven to four read zero
// - brown-out reset sets bit two, software clears
// - bad brown-out select sets bit one
// - pin select corruption flag zero after power-on
// - watchdog config fault flag zero after power-on
// - key 55h to flash control resets device
// - run-mode watchdog reset sets timeout, keeps powerdown
// - sleep watchdog reset clears pc, sets both
// - power-on clears timeout and powerdown flags
// - pin or brown-out reset keeps both flags
// - power-on disables all interrupt sources
// - power-on clears watchdog, time bases; watchdog runs
// - power-on switches every timer module off
// - power-on makes all port pins inputs
// - power-on: pc zero, stack pointer top
// - invalid pin select sets flag, delayed reset
// - invalid brown-out select: delayed reset, reload default
module rsf_reset_flags #(
    parameter SRESET_CYC = (`RSF_SRESET_NS * `RSF_CLK_MHZ + 999) / 1000
) (
    // clock and power-on reset
    input wire core_clk,
    input wire rstn,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // reset events from the rest of the device
    input wire brown_out_trip,
    input wire reset_pin_event,
    input wire wdt_timeout,
    input wire in_low_power,
    // reset effects
    output reg sys_reset,
    output reg core_ctx_clear,
    output reg por_state,
    output wire irq
);

// ----------------------------------------
// storage
// ----------------------------------------
reg [`RSF_FLAGS_W-1:0] flags_r;
reg to_r;
reg pdf_r;
reg [7:0] bod_sel_r;
reg [7:0] pin_sel_r;
reg [7:0] wdt_ctl_r;
reg [`RSF_IRQ_W-1:0] irq_stat_r;
reg [`RSF_IRQ_W-1:0] irq_mask_r;
reg [15:0] dly_cnt_r;
reg dly_run_r;
reg [3:0] pulse_cnt_r;
reg bor_seen_r;

wire wr_flags = reg_wr && (reg_addr == `RSF_OFF_FLAGS);
wire wr_stat = reg_wr && (reg_addr == `RSF_OFF_STATUS);
wire wr_flash = reg_wr && (reg_addr == `RSF_OFF_FLASH_CTL1);
wire wr_bod = reg_wr && (reg_addr == `RSF_OFF_BOD_SEL);
wire wr_pin = reg_wr && (reg_addr == `RSF_OFF_PIN_SEL);
wire wr_wdt = reg_wr && (reg_addr == `RSF_OFF_WDT_CTL);
wire wr_istat = reg_wr && (reg_addr == `RSF_OFF_IRQ_STAT);
wire wr_imask = reg_wr && (reg_addr == `RSF_OFF_IRQ_MASK);

// ----------------------------------------
// validity of control words
// ----------------------------------------
wire pin_bad = (pin_sel_r != `RSF_PIN_SEL_IO) && (pin_sel_r != `RSF_PIN_SEL_PIN);
wire bod_bad = (bod_sel_r != `RSF_BOD_POR) && (bod_sel_r != `RSF_BOD_V19) &&
    (bod_sel_r != `RSF_BOD_V255) && (bod_sel_r != `RSF_BOD_V315) &&
    (bod_sel_r != `RSF_BOD_V38) && (bod_sel_r != `RSF_BOD_OFF);
wire wdt_bad = (wdt_ctl_r != `RSF_WDT_OK_A) && (wdt_ctl_r != `RSF_WDT_OK_B);
wire any_bad = pin_bad || bod_bad || wdt_bad;
wire dly_done = dly_run_r && (dly_cnt_r == SRESET_CYC[15:0] - 16'h0001);
wire bor_active = brown_out_trip && (bod_sel_r != `RSF_BOD_OFF) && !in_low_power;
wire key_hit = wr_flash && (reg_wdata == `RSF_FLASH_KEY);
wire wdt_rst = wdt_timeout;
wire soft_rst = dly_done || key_hit || (bor_active && !bor_seen_r) || reset_pin_event;

// ----------------------------------------
// delay before a control-word reset
// ----------------------------------------
reg [15:0] dly_cnt_nxt;
reg dly_run_nxt;

always @* begin
    dly_cnt_nxt = 16'h0000;
    dly_run_nxt = 1'b0;
    if (any_bad && !dly_done) begin
        dly_run_nxt = 1'b1;
        if (dly_run_r) begin
            dly_cnt_nxt = dly_cnt_r + 16'h0001;
        end
    end
end

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        dly_cnt_r <= 16'h0000;
        dly_run_r <= 1'b0;
    end else begin
        dly_cnt_r <= dly_cnt_nxt;
        dly_run_r <= dly_run_nxt;
    end
end

// ----------------------------------------
// control words
// ----------------------------------------
reg [7:0] bod_sel_nxt;
reg [7:0] pin_sel_nxt;
reg [7:0] wdt_ctl_nxt;

always @* begin
    bod_sel_nxt = bod_sel_r;
    pin_sel_nxt = pin_sel_r;
    wdt_ctl_nxt = wdt_ctl_r;
    // a bad select word returns to its power-on value
    if (dly_done && bod_bad) begin
        bod_sel_nxt = `RSF_BOD_POR;
    end else if (wr_bod) begin
        bod_sel_nxt = reg_wdata;
    end
    // every reset but the watchdog reloads the pin select
    if (soft_rst) begin
        pin_sel_nxt = `RSF_PIN_SEL_POR;
    end else if (wr_pin) begin
        pin_sel_nxt = reg_wdata;
    end
    if (dly_done && wdt_bad) begin
        wdt_ctl_nxt = `RSF_WDT_CTL_POR;
    end else if (wr_wdt) begin
        wdt_ctl_nxt = reg_wdata;
    end
end

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        bod_sel_r <= `RSF_BOD_POR;
        pin_sel_r <= `RSF_PIN_SEL_POR;
        wdt_ctl_r <= `RSF_WDT_CTL_POR;
    end else begin
        bod_sel_r <= bod_sel_nxt;
        pin_sel_r <= pin_sel_nxt;
        wdt_ctl_r <= wdt_ctl_nxt;
    end
end

// ----------------------------------------
// reset cause flags
// ----------------------------------------
wire [`RSF_FLAGS_W-1:0] flag_set;
wire [`RSF_FLAGS_W-1:0] flag_keep;
wire [`RSF_FLAGS_W-1:0] flags_nxt;

assign flag_set[`RSF_BIT_WDCF] = dly_done && wdt_bad;
assign flag_set[`RSF_BIT_VSF] = dly_done && bod_bad;
assign flag_set[`RSF_BIT_BOR] = bor_active;
assign flag_set[`RSF_BIT_CWR] = dly_done && pin_bad;
assign flag_keep = wr_flags ? reg_wdata[`RSF_FLAGS_W-1:0] : {`RSF_FLAGS_W{1'b1}};

genvar gi;
generate
    for (gi = 0; gi < `RSF_FLAGS_W; gi = gi + 1) begin : g_flag
        // software writes zero to clear; a set in the same cycle wins
        assign flags_nxt[gi] = flag_set[gi] | (flags_r[gi] & flag_keep[gi]);
    end
endgenerate

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        flags_r <= 4'h0;
        bor_seen_r <= 1'b0;
    end else begin
        flags_r <= flags_nxt;
        bor_seen_r <= bor_active;
    end
end

// ----------------------------------------
// timeout and powerdown flags
// ----------------------------------------
reg to_nxt;
reg pdf_nxt;

always @* begin
    to_nxt = to_r;
    pdf_nxt = pdf_r;
    if (wdt_rst) begin
        to_nxt = 1'b1;
        if (in_low_power) begin
            pdf_nxt = 1'b1;
        end
    end else if (wr_stat) begin
        // pin and brown-out resets leave both alone
        to_nxt = reg_wdata[`RSF_BIT_TO];
        pdf_nxt = reg_wdata[`RSF_BIT_PDF];
    end
end

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        to_r <= 1'b0;
        pdf_r <= 1'b0;
    end else begin
        to_r <= to_nxt;
        pdf_r <= pdf_nxt;
    end
end

// ----------------------------------------
// reset pulse and effects
// ----------------------------------------
wire hard_rst = soft_rst || (wdt_rst && !in_low_power);
reg [3:0] pulse_cnt_nxt;
reg sys_reset_nxt;
reg ctx_clear_nxt;
reg por_state_nxt;

always @* begin
    pulse_cnt_nxt = pulse_cnt_r;
    sys_reset_nxt = 1'b0;
    por_state_nxt = por_state;
    if (hard_rst) begin
        pulse_cnt_nxt = `RSF_RST_PULSE;
        sys_reset_nxt = 1'b1;
    end else if (pulse_cnt_r != 4'h0) begin
        pulse_cnt_nxt = pulse_cnt_r - 4'h1;
        sys_reset_nxt = 1'b1;
    end
    // a sleep time-out only clears the core context
    ctx_clear_nxt = (wdt_rst && in_low_power) || (pulse_cnt_r != 4'h0);
    if (pulse_cnt_r == 4'h0) begin
        por_state_nxt = 1'b0;
    end
end

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        pulse_cnt_r <= `RSF_RST_PULSE;
        sys_reset <= 1'b1;
        core_ctx_clear <= 1'b1;
        por_state <= 1'b1;
    end else begin
        pulse_cnt_r <= pulse_cnt_nxt;
        sys_reset <= sys_reset_nxt;
        core_ctx_clear <= ctx_clear_nxt;
        por_state <= por_state_nxt;
    end
end

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------
wire [`RSF_IRQ_W-1:0] irq_ev;
wire [`RSF_IRQ_W-1:0] irq_clr;
wire [`RSF_IRQ_W-1:0] irq_stat_nxt;
wire [`RSF_IRQ_W-1:0] irq_mask_nxt;

assign irq_ev = {wdt_rst, key_hit, flag_set};
assign irq_clr = wr_istat ? reg_wdata[`RSF_IRQ_W-1:0] : 6'h00;
assign irq_mask_nxt = wr_imask ? reg_wdata[`RSF_IRQ_W-1:0] : irq_mask_r;

generate
    for (gi = 0; gi < `RSF_IRQ_W; gi = gi + 1) begin : g_irq
        // write one to clear; a new event in the same cycle wins
        assign irq_stat_nxt[gi] = irq_ev[gi] | (irq_stat_r[gi] & ~irq_clr[gi]);
    end
endgenerate

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        irq_stat_r <= 6'h00;
        irq_mask_r <= 6'h00;
    end else begin
        irq_stat_r <= irq_stat_nxt;
        irq_mask_r <= irq_mask_nxt;
    end
end

assign irq = |(irq_stat_r & irq_mask_r);

// ----------------------------------------
// read port
// ----------------------------------------
reg [7:0] rdata_nxt;

always @* begin
    rdata_nxt = `RSF_ZERO8;
    if (reg_rd) begin
        case (reg_addr)
            `RSF_OFF_FLAGS: rdata_nxt = {4'h0, flags_r};
            `RSF_OFF_STATUS: rdata_nxt = {6'h00, to_r, pdf_r};
            `RSF_OFF_BOD_SEL: rdata_nxt = bod_sel_r;
            `RSF_OFF_PIN_SEL: rdata_nxt = pin_sel_r;
            `RSF_OFF_WDT_CTL: rdata_nxt = wdt_ctl_r;
            `RSF_OFF_IRQ_STAT: rdata_nxt = {2'h0, irq_stat_r};
            `RSF_OFF_IRQ_MASK: rdata_nxt = {2'h0, irq_mask_r};
            default: rdata_nxt = `RSF_ZERO8;
        endcase
    end
end

// read data stand one cycle, then return to zero
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        reg_rdata <= `RSF_ZERO8;
    end else begin
        reg_rdata <= rdata_nxt;
    end
end

endmodule // rsf_reset_flags

/* include/rsf_regs.vh */
// register map, field positions, codes and timing counts of the reset-source flag block
// assumes 8-bit software register port on core_clk (50 MHz)
`ifndef RSF_REGS_VH
`define RSF_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSF_ADDR_W 4
`define RSF_OFF_FLAGS 4'h0
`define RSF_OFF_STATUS 4'h1
`define RSF_OFF_FLASH_CTL1 4'h2
`define RSF_OFF_BOD_SEL 4'h3
`define RSF_OFF_PIN_SEL 4'h4
`define RSF_OFF_WDT_CTL 4'h5
`define RSF_OFF_IRQ_STAT 4'h6
`define RSF_OFF_IRQ_MASK 4'h7

// ----------------------------------------
// reset_cause_flags fields
// ----------------------------------------
`define RSF_BIT_WDCF 0
`define RSF_BIT_VSF 1
`define RSF_BIT_BOR 2
`define RSF_BIT_CWR 3
`define RSF_FLAGS_W 4

// ----------------------------------------
// status register fields
// ----------------------------------------
`define RSF_BIT_PDF 0
`define RSF_BIT_TO 1

// ----------------------------------------
// irq status fields
// ----------------------------------------
`define RSF_IRQ_W 6
`define RSF_IRQ_SOFT 4
`define RSF_IRQ_WDT 5

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define RSF_FLASH_KEY 8'h55
`define RSF_PIN_SEL_IO 8'h55
`define RSF_PIN_SEL_PIN 8'haa
`define RSF_PIN_SEL_POR 8'h55
`define RSF_BOD_POR 8'h66
`define RSF_BOD_V19 8'h55
`define RSF_BOD_V255 8'h33
`define RSF_BOD_V315 8'h99
`define RSF_BOD_V38 8'haa
`define RSF_BOD_OFF 8'hf0
`define RSF_WDT_CTL_POR 8'h53
`define RSF_WDT_OK_A 8'h53
`define RSF_WDT_OK_B 8'hac
`define RSF_ZERO8 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define RSF_CLK_MHZ 50
`define RSF_SRESET_NS 2000
`define RSF_RST_PULSE 4'h8

`endif

/* testbench/rsf_reset_flags_monitor.sv */
// checker for the reset-source flag block
// bound to the ports of rsf_reset_flags
`timescale 1ns/1ps
`include "rsf_regs.vh"
module rsf_reset_flags_monitor #(
    parameter int SRESET_CYC = 100
) (
    // clock, reset, register port
    input logic core_clk,
    input logic rstn,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // events and effects
    input logic brown_out_trip,
    input logic wdt_timeout,
    input logic in_low_power,
    input logic sys_reset,
    input logic core_ctx_clear,
    input logic por_state
);
    localparam int DLY_HI = SRESET_CYC + 4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_flags_upper_zero: assert property (reg_rd && reg_addr == `RSF_OFF_FLAGS |=> reg_rdata[7:4] == 4'h0)
        else $error("flag register upper bits not zero");
    a_bod_forces_reset: assert property ($rose(brown_out_trip) && !in_low_power |-> ##[1:4] sys_reset)
        else $error("brown-out gave no reset");
    a_key_resets_device: assert property (reg_wr && reg_addr == `RSF_OFF_FLASH_CTL1
        && reg_wdata == `RSF_FLASH_KEY |-> ##[1:3] sys_reset)
        else $error("flash key gave no reset");
    a_wdt_run_reset: assert property (wdt_timeout && !in_low_power |-> ##[1:3] sys_reset)
        else $error("run-mode time-out gave no reset");
    a_wdt_sleep_ctx: assert property (wdt_timeout && in_low_power |=> core_ctx_clear)
        else $error("sleep time-out did not clear context");
    a_status_por_zero: assert property (por_state && reg_rd && reg_addr == `RSF_OFF_STATUS
        |=> reg_rdata == 8'h00)
        else $error("status not zero after power-on");
    a_por_holds_ctx: assert property (por_state |-> sys_reset && core_ctx_clear)
        else $error("power-on state without reset");
    a_por_ends_reset: assert property ($fell(por_state) |-> $fell(sys_reset))
        else $error("power-on state and reset end apart");
    a_pin_sel_bad: assert property (reg_wr && reg_addr == `RSF_OFF_PIN_SEL
        && reg_wdata != `RSF_PIN_SEL_IO && reg_wdata != `RSF_PIN_SEL_PIN
        |-> ##[1:DLY_HI] sys_reset)
        else $error("bad pin select gave no reset");
endmodule // rsf_reset_flags_monitor

bind rsf_reset_flags rsf_reset_flags_monitor #(.SRESET_CYC(SRESET_CYC)) u_mon (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .brown_out_trip(brown_out_trip), .wdt_timeout(wdt_timeout),
    .in_low_power(in_low_power), .sys_reset(sys_reset),
    .core_ctx_clear(core_ctx_clear), .por_state(por_state));

/* testbench/rsf_reset_flags_tb.sv */
// self-checking bench for the reset-source flag block
// drives the register port and event inputs directly
`timescale 1ns/1ps
`include "rsf_regs.vh"
module rsf_reset_flags_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic brown_out_trip = 1'b0;
    logic reset_pin_event = 1'b0;
    logic wdt_timeout = 1'b0;
    logic in_low_power = 1'b0;
    wire [7:0] reg_rdata;
    wire sys_reset, core_ctx_clear, por_state, irq;
    int num_errors = 0;
    int n_tests = 0;
    logic [3:0] bad_addr [3] = '{`RSF_OFF_BOD_SEL, `RSF_OFF_PIN_SEL, `RSF_OFF_WDT_CTL};
    logic [7:0] bad_data [3] = '{8'h12, 8'h00, 8'h00};
    logic [7:0] flag_exp [3] = '{8'h02, 8'h08, 8'h01};
    logic [7:0] por_val [3] = '{`RSF_BOD_POR, `RSF_PIN_SEL_POR, `RSF_WDT_CTL_POR};

    rsf_reset_flags #(.SRESET_CYC(4)) u_dut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .brown_out_trip(brown_out_trip), .reset_pin_event(reset_pin_event),
        .wdt_timeout(wdt_timeout), .in_low_power(in_low_power), .sys_reset(sys_reset),
        .core_ctx_clear(core_ctx_clear), .por_state(por_state), .irq(irq));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
        @(negedge core_clk);
        chk(reg_rdata, 8'h00);
    endtask

    task automatic ev(input logic [2:0] m);
        @(posedge core_clk);
        {brown_out_trip, reset_pin_event, wdt_timeout} <= m;
        @(posedge core_clk);
        {brown_out_trip, reset_pin_event, wdt_timeout} <= 3'b000;
    endtask

    task automatic wait_sys(input logic lvl);
        int i;
        i = 0;
        while (sys_reset !== lvl && i < 40) begin
            @(negedge core_clk);
            i++;
        end
        chk({7'h00, sys_reset}, {7'h00, lvl});
        if (sys_reset !== lvl)
            tally_and_finish();
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`RSF_OFF_FLAGS, 8'h00);
        rd(`RSF_OFF_STATUS, 8'h00);
        chk({7'h00, por_state}, 8'h01);
        wait_sys(1'b0);
        chk({7'h00, por_state}, 8'h00);
        $display("power-on test done");
        wr(`RSF_OFF_STATUS, 8'h03);
        ev(3'b100);
        wait_sys(1'b1);
        wait_sys(1'b0);
        ev(3'b010);
        wait_sys(1'b1);
        wait_sys(1'b0);
        rd(`RSF_OFF_STATUS, 8'h03);
        rd(`RSF_OFF_FLAGS, 8'h04);
        wr(`RSF_OFF_FLAGS, 8'h00);
        rd(`RSF_OFF_FLAGS, 8'h00);
        @(posedge core_clk);
        brown_out_trip <= 1'b1;
        wr(`RSF_OFF_FLAGS, 8'h00);
        brown_out_trip <= 1'b0;
        wait_sys(1'b0);
        rd(`RSF_OFF_FLAGS, 8'h04);
        wr(`RSF_OFF_FLAGS, 8'h00);
        $display("brown-out test done");
        for (int k = 0; k < 3; k++) begin
            wr(bad_addr[k], bad_data[k]);
            wait_sys(1'b1);
            wait_sys(1'b0);
            rd(`RSF_OFF_FLAGS, flag_exp[k]);
            rd(bad_addr[k], por_val[k]);
            wr(`RSF_OFF_FLAGS, 8'h00);
        end
        $display("control word test done");
        wr(`RSF_OFF_FLASH_CTL1, `RSF_FLASH_KEY);
        wait_sys(1'b1);
        wait_sys(1'b0);
        wr(`RSF_OFF_STATUS, 8'h00);
        ev(3'b001);
        wait_sys(1'b1);
        wait_sys(1'b0);
        rd(`RSF_OFF_STATUS, 8'h02);
        $display("run time-out test done");
        wr(`RSF_OFF_STATUS, 8'h00);
        wr(`RSF_OFF_IRQ_STAT, 8'h3f);
        wr(`RSF_OFF_IRQ_MASK, 8'h20);
        in_low_power <= 1'b1;
        ev(3'b001);
        @(negedge core_clk);
        chk({6'h00, core_ctx_clear, sys_reset}, 8'h02);
        chk({7'h00, irq}, 8'h01);
        rd(`RSF_OFF_STATUS, 8'h03);
        wr(`RSF_OFF_IRQ_MASK, 8'h00);
        @(negedge core_clk);
        chk({7'h00, irq}, 8'h00);
        wr(`RSF_OFF_IRQ_MASK, 8'h20);
        wr(`RSF_OFF_IRQ_STAT, 8'h20);
        @(negedge core_clk);
        chk({7'h00, irq}, 8'h00);
        rd(4'h8, 8'h00);
        in_low_power <= 1'b0;
        $display("sleep time-out test done");
        tally_and_finish();
    end
endmodule // rsf_reset_flags_tb
